/* File: shared/tm3_pkg.sv */
// constants, register map and field layout of the timer 3 block
package tm3_pkg;

  // ==========================================================
  // register addresses on the special function register port
  localparam logic [7:0] TM3_ADDR_CONTROL     = 8'h91;
  localparam logic [7:0] TM3_ADDR_RELOAD_LOW  = 8'h92;
  localparam logic [7:0] TM3_ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] TM3_ADDR_COUNT_LOW   = 8'h94;
  localparam logic [7:0] TM3_ADDR_COUNT_HIGH  = 8'h95;

  // ==========================================================
  // control register fields
  localparam int TM3_CTL_HIGH_FLAG_BIT   = 7;
  localparam int TM3_CTL_LOW_FLAG_BIT    = 6;
  localparam int TM3_CTL_LOW_IRQ_EN_BIT  = 5;
  localparam int TM3_CTL_CAPTURE_EN_BIT  = 4;
  localparam int TM3_CTL_SPLIT_BIT       = 3;
  localparam int TM3_CTL_RUN_BIT         = 2;
  localparam int TM3_CTL_ALT_CLK_MSB     = 1;
  localparam int TM3_CTL_ALT_CLK_LSB     = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] TM3_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TM3_RELOAD_RESET  = 8'h00;
  localparam logic [7:0] TM3_COUNT_RESET   = 8'h00;
  localparam logic [7:0] TM3_UNMAPPED_READ = 8'h00;

  // ==========================================================
  // byte limits
  localparam logic [7:0] TM3_BYTE_MAX  = 8'hff;
  localparam logic [7:0] TM3_BYTE_ZERO = 8'h00;
  localparam logic [7:0] TM3_BYTE_ONE  = 8'h01;

  // ==========================================================
  // timing: system clock prescale and synchroniser depth
  localparam int TM3_SYSDIV_DEFAULT = 12;
  localparam int TM3_SYNC_STAGES    = 2;

  // ==========================================================
  // alternate clock source selection
  typedef enum logic [1:0] {
    TM3_ALT_SYSDIV12 = 2'b00,
    TM3_ALT_EXT_DIV8 = 2'b01,
    TM3_ALT_RESERVED = 2'b10,
    TM3_ALT_LFO_DIV8 = 2'b11
  } tm3_alt_clk_type;

endpackage

/* File: hdl/tm3_clk_sync.sv */
// synchroniser with edge pulses for one slow clock source
`timescale 1ns/1ns
module tm3_clk_sync
  import tm3_pkg::*;
#(
  parameter int STAGES = TM3_SYNC_STAGES
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      rise_pulse,
  output logic      fall_pulse
);

  // ==========================================================
  // elaboration check
  if (STAGES < 2) begin : g_bad_stages
    $error("tm3_clk_sync needs at least two stages");
  end

  // ==========================================================
  // flop chain; stage 0 feeds only stage 1
  logic [STAGES-1:0] sync_q;
  logic              last_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_q <= '0;
      last_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], async_in};
      last_q <= sync_q[STAGES-1];
    end
  end

  // ==========================================================
  // edges seen only past the last stage
  assign rise_pulse = sync_q[STAGES-1] & ~last_q;
  assign fall_pulse = ~sync_q[STAGES-1] & last_q;

endmodule

/* File: hdl/tm3_timer.sv */
// timer 3 control, reload and count registers with auto-reload counting
// ==========================================================
`timescale 1ns/1ns
module tm3_timer
  import tm3_pkg::*;
#(
  parameter int SYSDIV = TM3_SYSDIV_DEFAULT
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer_irq_enable,
  input  wire logic       upper_byte_system_clock_select,
  input  wire logic       lower_byte_system_clock_select,
  input  wire logic       ext_osc_div8,
  input  wire logic       lfo_div8,
  input  wire logic       low_freq_oscillator,
  output logic            timer_irq_req
);

  // ==========================================================
  // elaboration check
  if (SYSDIV < 2) begin : g_bad_sysdiv
    $error("tm3_timer needs a system clock divider of at least two");
  end

  localparam int PW = $clog2(SYSDIV);
  localparam logic [PW-1:0] PRE_LAST = PW'(SYSDIV - 1);
  localparam logic [PW-1:0] PRE_ZERO = '0;
  localparam logic [PW-1:0] PRE_ONE  = PW'(1);

  // ==========================================================
  // decode helpers
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  function automatic logic byte_tick(input logic system_clock_sel, input logic alt_tick);
    // system clock ticks on every edge
    byte_tick = system_clock_sel | alt_tick;
  endfunction

  // ==========================================================
  // register state
  logic            high_overflow_flag_q;
  logic            low_overflow_flag_q;
  logic            low_byte_irq_enable_q;
  logic            osc_capture_enable_q;
  logic            split_mode_q;
  logic            run_control_q;
  tm3_alt_clk_type alt_clock_select_q;
  logic [7:0]      reload_low_q;
  logic [7:0]      reload_high_q;
  logic [7:0]      count_low_q;
  logic [7:0]      count_high_q;
  logic [7:0]      count_low_d;
  logic [7:0]      count_high_d;
  logic [7:0]      sfr_rdata_q;
  logic [PW-1:0]   prescale_q;

  // ==========================================================
  // write strobes
  logic wr_control;
  logic wr_reload_low;
  logic wr_reload_high;
  logic wr_count_low;
  logic wr_count_high;

  assign wr_control     = sfr_wr & addr_hit(sfr_addr, TM3_ADDR_CONTROL);
  assign wr_reload_low  = sfr_wr & addr_hit(sfr_addr, TM3_ADDR_RELOAD_LOW);
  assign wr_reload_high = sfr_wr & addr_hit(sfr_addr, TM3_ADDR_RELOAD_HIGH);
  assign wr_count_low   = sfr_wr & addr_hit(sfr_addr, TM3_ADDR_COUNT_LOW);
  assign wr_count_high  = sfr_wr & addr_hit(sfr_addr, TM3_ADDR_COUNT_HIGH);

  // ==========================================================
  // slow source synchronisers
  // a source idling high as reset lifts gives one spurious first tick
  logic [2:0] src_raw;
  logic [2:0] src_rise;
  logic [2:0] src_fall;

  assign src_raw = {low_freq_oscillator, lfo_div8, ext_osc_div8};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    tm3_clk_sync #(
      .STAGES     (TM3_SYNC_STAGES)
    ) u_sync (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .async_in   (src_raw[i]),
      .rise_pulse (src_rise[i]),
      .fall_pulse (src_fall[i])
    );
  end

  logic ext_tick;
  logic lfo_tick;
  logic lfo_fall;

  assign ext_tick = src_rise[0];
  assign lfo_tick = src_rise[1];
  assign lfo_fall = src_fall[2];

  // ==========================================================
  // system clock prescaler
  // free-running, so the first divided tick after run is set may come early
  logic sysdiv_tick;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prescale_q <= PRE_ZERO;
    end else if (prescale_q == PRE_LAST) begin
      prescale_q <= PRE_ZERO;
    end else begin
      prescale_q <= prescale_q + PRE_ONE;
    end
  end

  assign sysdiv_tick = (prescale_q == PRE_LAST);

  // ==========================================================
  // alternate source decode, shared by both bytes
  logic alt_tick;

  always_comb begin
    case (alt_clock_select_q)
      TM3_ALT_SYSDIV12: alt_tick = sysdiv_tick;
      TM3_ALT_EXT_DIV8: alt_tick = ext_tick;
      TM3_ALT_LFO_DIV8: alt_tick = lfo_tick;
      TM3_ALT_RESERVED: alt_tick = 1'b0; // reserved code never ticks
      default:          alt_tick = 1'b0;
    endcase
  end

  logic tick_low;
  logic tick_high;

  assign tick_low  = byte_tick(lower_byte_system_clock_select, alt_tick);
  assign tick_high = byte_tick(upper_byte_system_clock_select, alt_tick);

  // ==========================================================
  // count enables and wrap detection
  logic low_step;
  logic high_step;
  logic low_wrap;
  logic high_wrap;

  always_comb begin
    if (split_mode_q) begin
      low_step  = tick_low; // lower byte always runs
      high_step = run_control_q & tick_high;
      low_wrap  = low_step & (count_low_q == TM3_BYTE_MAX);
      high_wrap = high_step & (count_high_q == TM3_BYTE_MAX);
    end else begin
      // 16-bit mode steps on the lower byte source
      low_step  = run_control_q & tick_low;
      low_wrap  = low_step & (count_low_q == TM3_BYTE_MAX);
      high_step = low_wrap;
      high_wrap = low_wrap & (count_high_q == TM3_BYTE_MAX);
    end
  end

  // ==========================================================
  // count next values; a software write beats a same-cycle step
  always_comb begin
    count_low_d = count_low_q;
    if (wr_count_low) begin
      count_low_d = sfr_wdata;
    end else if (low_wrap) begin
      if (split_mode_q) begin
        count_low_d = reload_low_q;
      end else if (high_wrap) begin
        count_low_d = reload_low_q;
      end else begin
        count_low_d = TM3_BYTE_ZERO;
      end
    end else if (low_step) begin
      count_low_d = count_low_q + TM3_BYTE_ONE;
    end
  end

  always_comb begin
    count_high_d = count_high_q;
    if (wr_count_high) begin
      count_high_d = sfr_wdata;
    end else if (high_wrap) begin
      // split reloads its own byte, 16-bit reloads the pair
      count_high_d = reload_high_q;
    end else if (high_step) begin
      count_high_d = count_high_q + TM3_BYTE_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_low_q  <= TM3_COUNT_RESET;
      count_high_q <= TM3_COUNT_RESET;
    end else begin
      count_low_q  <= count_low_d;
      count_high_q <= count_high_d;
    end
  end

  // ==========================================================
  // capture of the count on a low-frequency falling edge
  logic capture_evt;

  assign capture_evt = osc_capture_enable_q & lfo_fall;

  // capture beats a same-cycle software write to the reload pair
  // in split mode the capture takes both byte counters as they stand
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reload_low_q  <= TM3_RELOAD_RESET;
      reload_high_q <= TM3_RELOAD_RESET;
    end else if (capture_evt) begin
      reload_low_q  <= count_low_q;
      reload_high_q <= count_high_q;
    end else begin
      if (wr_reload_low) begin
        reload_low_q <= sfr_wdata;
      end
      if (wr_reload_high) begin
        reload_high_q <= sfr_wdata;
      end
    end
  end

  // ==========================================================
  // control fields written by software
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      low_byte_irq_enable_q <= TM3_CONTROL_RESET[TM3_CTL_LOW_IRQ_EN_BIT];
      osc_capture_enable_q  <= TM3_CONTROL_RESET[TM3_CTL_CAPTURE_EN_BIT];
      split_mode_q          <= TM3_CONTROL_RESET[TM3_CTL_SPLIT_BIT];
      run_control_q         <= TM3_CONTROL_RESET[TM3_CTL_RUN_BIT];
      alt_clock_select_q    <= tm3_alt_clk_type'(TM3_CONTROL_RESET[TM3_CTL_ALT_CLK_MSB:TM3_CTL_ALT_CLK_LSB]);
    end else if (wr_control) begin
      low_byte_irq_enable_q <= sfr_wdata[TM3_CTL_LOW_IRQ_EN_BIT];
      osc_capture_enable_q  <= sfr_wdata[TM3_CTL_CAPTURE_EN_BIT];
      split_mode_q          <= sfr_wdata[TM3_CTL_SPLIT_BIT];
      run_control_q         <= sfr_wdata[TM3_CTL_RUN_BIT];
      alt_clock_select_q    <= tm3_alt_clk_type'(sfr_wdata[TM3_CTL_ALT_CLK_MSB:TM3_CTL_ALT_CLK_LSB]);
    end
  end

  // ==========================================================
  // overflow flags; a hardware set wins over a same-cycle clear
  logic high_set;
  logic low_set;

  assign high_set = high_wrap | capture_evt;
  assign low_set  = low_wrap;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      high_overflow_flag_q <= TM3_CONTROL_RESET[TM3_CTL_HIGH_FLAG_BIT];
    end else if (high_set) begin
      high_overflow_flag_q <= 1'b1;
    end else if (wr_control) begin
      // only software changes it otherwise, no clear on interrupt entry
      high_overflow_flag_q <= sfr_wdata[TM3_CTL_HIGH_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      low_overflow_flag_q <= TM3_CONTROL_RESET[TM3_CTL_LOW_FLAG_BIT];
    end else if (low_set) begin
      low_overflow_flag_q <= 1'b1;
    end else if (wr_control) begin
      low_overflow_flag_q <= sfr_wdata[TM3_CTL_LOW_FLAG_BIT];
    end
  end

  // ==========================================================
  // interrupt request, a level that follows the flags
  assign timer_irq_req = timer_irq_enable &
                         (high_overflow_flag_q | (low_byte_irq_enable_q & low_overflow_flag_q));

  // ==========================================================
  // read path; registered, so data follow the read strobe by one cycle
  logic [7:0] control_view;
  logic [7:0] rdata_d;

  always_comb begin
    control_view = TM3_CONTROL_RESET;
    control_view[TM3_CTL_HIGH_FLAG_BIT]  = high_overflow_flag_q;
    control_view[TM3_CTL_LOW_FLAG_BIT]   = low_overflow_flag_q;
    control_view[TM3_CTL_LOW_IRQ_EN_BIT] = low_byte_irq_enable_q;
    control_view[TM3_CTL_CAPTURE_EN_BIT] = osc_capture_enable_q;
    control_view[TM3_CTL_SPLIT_BIT]      = split_mode_q;
    control_view[TM3_CTL_RUN_BIT]        = run_control_q;
    control_view[TM3_CTL_ALT_CLK_MSB:TM3_CTL_ALT_CLK_LSB] = alt_clock_select_q;
  end

  always_comb begin
    case (sfr_addr)
      TM3_ADDR_CONTROL:     rdata_d = control_view;
      TM3_ADDR_RELOAD_LOW:  rdata_d = reload_low_q;
      TM3_ADDR_RELOAD_HIGH: rdata_d = reload_high_q;
      TM3_ADDR_COUNT_LOW:   rdata_d = count_low_q;
      TM3_ADDR_COUNT_HIGH:  rdata_d = count_high_q;
      default:              rdata_d = TM3_UNMAPPED_READ;
    endcase
  end

  // reads have no side effects, so holding between strobes is safe
  // the 16-bit count is not snapshotted, so a low-then-high read may tear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sfr_rdata_q <= TM3_UNMAPPED_READ;
    end else if (sfr_rd) begin
      sfr_rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = sfr_rdata_q;

endmodule

/* File: sim/tm3_timer_assertions.sv */
// port-level concurrent checks for the timer 3 register block
`timescale 1ns/1ns
module tm3_timer_assertions
  import tm3_pkg::*;
#(
  parameter int SYSDIV = TM3_SYSDIV_DEFAULT
) (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       timer_irq_enable,
  input wire logic       timer_irq_req
);
  // ==========================================================
  // register access steps
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence wr_s(logic [7:0] a);
    sfr_wr && sfr_addr == a;
  endsequence
  sequence rd_s(logic [7:0] a);
    sfr_rd && sfr_addr == a;
  endsequence
  // ==========================================================
  // checks
  irq_masked_a:
    assert property (!timer_irq_enable |-> !timer_irq_req) else $error("irq without enable");
  high_irq_a:
    assert property (wr_s(TM3_ADDR_CONTROL) ##0 sfr_wdata[7] ##1 timer_irq_enable |-> timer_irq_req)
      else $error("high flag gives no irq");
  low_irq_a:
    assert property (wr_s(TM3_ADDR_CONTROL) ##0 (sfr_wdata[6] && sfr_wdata[5]) ##1 timer_irq_enable
      |-> timer_irq_req) else $error("low flag gives no irq");
  flag_hold_a:
    assert property (timer_irq_req && !sfr_wr ##1 timer_irq_enable |-> timer_irq_req)
      else $error("flag cleared without write");
  reload_lo_a:
    assert property (wr_s(TM3_ADDR_RELOAD_LOW) ##2 rd_s(TM3_ADDR_RELOAD_LOW)
      |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("reload low readback");
  reload_hi_a:
    assert property (wr_s(TM3_ADDR_RELOAD_HIGH) ##2 rd_s(TM3_ADDR_RELOAD_HIGH)
      |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("reload high readback");
  rdata_hold_a:
    assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
  unmapped_zero_a:
    assert property (sfr_rd && !(sfr_addr inside {[8'h91:8'h95]}) |=> sfr_rdata == TM3_UNMAPPED_READ)
      else $error("unmapped read not zero");
  reset_clear_a:
    assert property ($fell(srst) |-> !timer_irq_req && sfr_rdata == TM3_BYTE_ZERO)
      else $error("reset left state");
endmodule

bind tm3_timer tm3_timer_assertions #(.SYSDIV(SYSDIV)) i_tm3_timer_assertions (
  .clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable),
  .timer_irq_req(timer_irq_req)
);

/* File: sim/tb_top.sv */
// self-checking bench for the timer 3 register block
`timescale 1ns/1ns
module tb_top
  import tm3_pkg::*;
;
  logic       clk_sys, srst, sfr_wr, sfr_rd, timer_irq_enable, timer_irq_req;
  logic       upper_sel, lower_sel, ext_osc_div8, lfo_div8, low_freq_oscillator;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_q;
  int         fail_count = 0;
  int         checks = 0;
  logic [7:0] exp_cnt [4] = '{8'h00, 8'h03, 8'h00, 8'h05};

  // short prescale keeps the system_clock/12 path cheap
  tm3_timer #(.SYSDIV(3)) i_tm3_timer (
    .clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable),
    .upper_byte_system_clock_select(upper_sel), .lower_byte_system_clock_select(lower_sel),
    .ext_osc_div8(ext_osc_div8), .lfo_div8(lfo_div8), .low_freq_oscillator(low_freq_oscillator),
    .timer_irq_req(timer_irq_req)
  );

  always #25 clk_sys = ~clk_sys;

  // ==========================================================
  // access tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes dropped one edge before the next access, never re-raised in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk_sys) #1;
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys) #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk_sys) #1;
    sfr_rd = 1'b0;
    rd_q = sfr_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(rd_q, exp);
  endtask

  // slow sources held 4 cycles each level, above the synchroniser minimum
  task automatic pulse(input logic e, input logic l, input logic f);
    @(posedge clk_sys) #1;
    ext_osc_div8 = e;
    lfo_div8 = l;
    low_freq_oscillator = f;
    repeat (4) @(posedge clk_sys);
    #1;
    ext_osc_div8 = 1'b0;
    lfo_div8 = 1'b0;
    low_freq_oscillator = 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // test sequence
  initial begin
    clk_sys = 1'b0;
    srst = 1'b1;
    {sfr_wr, sfr_rd, timer_irq_enable, upper_sel, lower_sel} = 5'h00;
    {ext_osc_div8, lfo_div8, low_freq_oscillator} = 3'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    repeat (20) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    for (int a = 8'h90; a <= 8'h95; a++) rdc(8'(a), TM3_BYTE_ZERO);
    wr(TM3_ADDR_RELOAD_LOW, 8'ha5);
    rdc(TM3_ADDR_RELOAD_LOW, 8'ha5);
    wr(TM3_ADDR_RELOAD_HIGH, 8'h3c);
    rdc(TM3_ADDR_RELOAD_HIGH, 8'h3c);
    wr(8'h90, 8'hff);
    rdc(8'h90, TM3_UNMAPPED_READ);
    // full 16-bit wrap, stop write lands on the wrap edge
    wr(TM3_ADDR_RELOAD_LOW, 8'h34);
    wr(TM3_ADDR_RELOAD_HIGH, 8'h12);
    wr(TM3_ADDR_COUNT_LOW, 8'hfe);
    wr(TM3_ADDR_COUNT_HIGH, 8'hff);
    lower_sel = 1'b1;
    timer_irq_enable = 1'b1;
    wr(TM3_ADDR_CONTROL, 8'h04);
    wr(TM3_ADDR_CONTROL, 8'h00);
    rdc(TM3_ADDR_COUNT_LOW, 8'h34);
    rdc(TM3_ADDR_COUNT_HIGH, 8'h12);
    chk(8'(timer_irq_req), 8'h01);
    timer_irq_enable = 1'b0;
    #1 chk(8'(timer_irq_req), 8'h00);
    repeat (6) @(posedge clk_sys);
    rdc(TM3_ADDR_CONTROL, 8'hc0);
    // split mode: low byte free-running, high byte gated by run
    timer_irq_enable = 1'b1;
    wr(TM3_ADDR_RELOAD_LOW, 8'h80);
    wr(TM3_ADDR_RELOAD_HIGH, 8'h40);
    wr(TM3_ADDR_COUNT_LOW, 8'hff);
    wr(TM3_ADDR_COUNT_HIGH, 8'hff);
    wr(TM3_ADDR_CONTROL, 8'h0a);
    @(posedge clk_sys) #1;
    lower_sel = 1'b0;
    upper_sel = 1'b1;
    wr(TM3_ADDR_CONTROL, 8'h4e);
    wr(TM3_ADDR_CONTROL, 8'hca);
    upper_sel = 1'b0;
    rdc(TM3_ADDR_COUNT_LOW, 8'h80);
    rdc(TM3_ADDR_COUNT_HIGH, 8'h41);
    rdc(TM3_ADDR_CONTROL, 8'hca);
    wr(TM3_ADDR_CONTROL, 8'h40);
    chk(8'(timer_irq_req), 8'h00);
    wr(TM3_ADDR_CONTROL, 8'h60);
    chk(8'(timer_irq_req), 8'h01);
    wr(TM3_ADDR_CONTROL, 8'h00);
    chk(8'(timer_irq_req), 8'h00);
    // each alternate source: 3 external and 5 low-frequency rises
    for (int s = 0; s < 4; s++) begin
      wr(TM3_ADDR_COUNT_LOW, 8'h00);
      wr(TM3_ADDR_CONTROL, 8'(4 + s));
      for (int i = 0; i < 5; i++) pulse(i < 3, 1'b1, 1'b0);
      wr(TM3_ADDR_CONTROL, 8'(s));
      if (s == 0) begin
        // prescaler phase is free-running, so only a range is known here
        rd(TM3_ADDR_COUNT_LOW);
        chk(8'(rd_q inside {[8'd14:8'd17]}), 8'h01);
      end else begin
        rdc(TM3_ADDR_COUNT_LOW, exp_cnt[s]);
      end
    end
    // no low wrap in the 16-bit source runs, so the high byte held
    rdc(TM3_ADDR_COUNT_HIGH, 8'h41);
    // capture on the falling oscillator edge
    wr(TM3_ADDR_COUNT_LOW, 8'h55);
    wr(TM3_ADDR_COUNT_HIGH, 8'h66);
    wr(TM3_ADDR_CONTROL, 8'h10);
    pulse(1'b0, 1'b0, 1'b1);
    rdc(TM3_ADDR_RELOAD_LOW, 8'h55);
    rdc(TM3_ADDR_RELOAD_HIGH, 8'h66);
    rdc(TM3_ADDR_CONTROL, 8'h90);
    chk(8'(timer_irq_req), 8'h01);
    finish_test();
  end
endmodule
